// File: logic/alu_dp.sv
// alu, barrel shifter and status update behind an apb slave
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "alu_dp_regs.svh"

// Behaviour
// - logical opcodes and/xor/or/copy/bit-clear/copy-inverted; copies ignore operand one
// - arithmetic opcodes minus, reverse, sum, with-carry forms use status carry
// - opcodes 1000-1011 compute and/xor/minus/sum, only set flags
// - logical flag set: v kept, c from shifter, z zero, n bit 31
// - arithmetic flag set: v signed overflow, c alu carry, z, n
// - immediate shift amount 5 bits; type picks lsl, lsr, asr, ror
// - left shift zero-fills; amount zero passes operand with old carry
// - right shift zero-fills; immediate zero means shift by 32
// - arithmetic right sign-fills; immediate zero means shift by 32
// - rotate wraps; immediate zero rotates carry:operand right one
// - register count uses low byte; zero passes with old carry
// - logical shifts by 32 zero result with edge bit carry; beyond zero
// - asr 32+ fills sign; ror 32 unchanged; ror beyond reduces modulo
// - register shift with bit seven set is not data processing
// - immediate is 8 bits zero-extended, rotated right twice rotate field
// - pc dest with flags loads nzcv; privileged also irq and mode bits
// - pc dest without flags writes pc bits only
// - test opcodes with pc dest and flags update unprotected status bits
// - pc as shifted operand carries status; elsewhere status bits zero
// - pc operand is address plus 8, or plus 12 as rn or rm with register shifts
// - flag-load test replaces nzcv with result; privileged also irq and mode bits
// - second operand is shifted register or rotated immediate by select bit
module alu_dp
  import alu_dp_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  logic [31:0] instr_r, opa_r, opb_r, cnt_r, iaddr_r, status_r, res_r;
  logic [7:0]  info_r;
  logic [31:0] prdata_r;
  logic        pready_r, pslverr_r, exec_r;
  logic        acc, wr_acc;
  logic [31:0] rd_val;
  logic        rd_hit;
  // decoded instruction
  alu_op_type     op;
  shift_kind_type sk;
  logic        s_bit, imm_sel, reg_sh, rd_pc, undef, is_test, arith, user;
  logic [31:0] pc_base, pc_shift_cnt, val_a, val_m, val_s, op2;
  logic [32:0] sh_out;
  logic        sh_c;
  logic [31:0] alu_res, x, y;
  logic        ci, alu_c, alu_v;
  logic [32:0] sum;
  logic [31:0] stat_nxt;
  logic        wr_dest, wr_pc, mode_chg;

  // true for the arithmetic class of opcodes
  function automatic logic is_arith_op(input logic [3:0] o);
    return (o[3:2] == 2'b01) || (o[3:1] == 3'b001) || (o[3:1] == 3'b101);
  endfunction

  // barrel shifter, returns {result, carry}
  function automatic logic [32:0] barrel(input logic [31:0] v, input shift_kind_type k,
                                         input logic [7:0] amt, input logic imm_form,
                                         input logic cin);
    logic [63:0] t;
    logic [7:0]  eff;
    logic [31:0] r;
    logic        c;
    t   = '0;
    r   = v;
    c   = cin;
    // immediate zero is a 32 shift for right shifts, plain pass for left
    eff = (imm_form && amt == 8'h00 && k != logical_left_shift) ? `WORD_BITS : amt;
    if (imm_form && amt == 8'h00 && k == rotate_right)
    begin
      r = {cin, v[31:1]};
      c = v[0];
    end
    else if (eff != 8'h00)
    begin
      case (k)
        logical_left_shift:
        begin
          t = {32'h0, v} << eff;
          r = (eff > `WORD_BITS) ? 32'h0 : t[31:0];
          c = (eff > `WORD_BITS) ? 1'b0 : t[32];
        end
        logical_right_shift:
        begin
          t = {v, 32'h0} >> eff;
          r = (eff > `WORD_BITS) ? 32'h0 : t[63:32];
          c = (eff > `WORD_BITS) ? 1'b0 : t[31];
        end
        arith_right_shift:
        begin
          t = 64'($signed({v, 32'h0}) >>> ((eff > `WORD_BITS) ? `WORD_BITS : eff));
          r = t[63:32];
          c = t[31];
        end
        default:
        begin
          t = {v, v} >> eff[4:0];
          r = t[31:0];
          c = r[31];
        end
      endcase
    end
    return {r, c};
  endfunction

  // register decode, byte offsets on aligned words
  always_comb
  begin
    rd_hit = 1'b1;
    case (paddr)
      `OFS_INSTR: rd_val = instr_r;
      `OFS_OPA:   rd_val = opa_r;
      `OFS_OPB:   rd_val = opb_r;
      `OFS_CNT:   rd_val = cnt_r;
      `OFS_IADDR: rd_val = iaddr_r;
      `OFS_STAT:  rd_val = status_r;
      `OFS_GO:    rd_val = {31'h0, exec_r};
      `OFS_RES:   rd_val = res_r;
      `OFS_INFO:  rd_val = {24'h0, info_r};
      default:
      begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign acc    = psel && penable;
  assign wr_acc = acc && pready_r && pwrite && rd_hit;

  // apb answer one cycle into the access phase, data held with ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= acc && !pready_r;
      pslverr_r <= acc && !pready_r && !rd_hit;
      if (acc && !pready_r)
        prdata_r <= pwrite ? 32'h0 : rd_val;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // operand and instruction registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_r <= 32'h0;
      opa_r   <= 32'h0;
      opb_r   <= 32'h0;
      cnt_r   <= 32'h0;
    end
    else if (wr_acc)
    begin
      if (paddr == `OFS_INSTR) instr_r <= pwdata;
      if (paddr == `OFS_OPA)   opa_r   <= pwdata;
      if (paddr == `OFS_OPB)   opb_r   <= pwdata;
      if (paddr == `OFS_CNT)   cnt_r   <= pwdata;
    end
  end

  // go strobe: execution happens in the cycle after the write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      exec_r <= 1'b0;
    else
      exec_r <= wr_acc && paddr == `OFS_GO && pwdata[0];
  end

  // field decode
  assign op      = alu_op_type'(instr_r[`F_OP]);
  assign sk      = shift_kind_type'(instr_r[`F_STYPE]);
  assign s_bit   = instr_r[`F_S];
  assign imm_sel = instr_r[`F_IMM];
  assign reg_sh  = !imm_sel && instr_r[`F_REGSH];
  assign rd_pc   = instr_r[`F_RD] == `PC_REG;
  assign is_test = instr_r[24:23] == 2'b10;
  assign arith   = is_arith_op(instr_r[`F_OP]);
  assign user    = status_r[`ST_MODE] == `USER_MODE;
  // bit seven with register shift is not ours
  assign undef   = reg_sh && instr_r[`F_B7];

  // prefetch offset depends on shift form
  assign pc_base      = iaddr_r + (reg_sh ? `PC_AHEAD_REG : `PC_AHEAD);
  assign pc_shift_cnt = (iaddr_r + `PC_AHEAD) & `PC_MASK;

  // status bits only reach the shifter input
  assign val_a = (instr_r[`F_RN] == `PC_REG) ? (pc_base & `PC_MASK) : opa_r;
  assign val_m = (instr_r[`F_RM] == `PC_REG) ?
                 ((pc_base & `PC_MASK) | (status_r & ~`PC_MASK)) : opb_r;
  assign val_s = (instr_r[`F_RS] == `PC_REG) ? pc_shift_cnt : cnt_r;

  always_comb
  begin
    if (imm_sel)
      // rotated immediate; rotate of zero keeps the old carry
      sh_out = barrel({24'h0, instr_r[`F_IMM8]}, rotate_right,
                      {3'h0, instr_r[`F_ROT], 1'b0}, 1'b0, status_r[`ST_C]);
    else if (reg_sh)
      // low byte of the count register
      sh_out = barrel(val_m, sk, val_s[7:0], 1'b0, status_r[`ST_C]);
    else
      sh_out = barrel(val_m, sk, {3'h0, instr_r[`F_SAMT]}, 1'b1, status_r[`ST_C]);
  end

  assign op2  = sh_out[32:1];
  assign sh_c = sh_out[0];

  // alu: subtraction is done as addition of the inverted operand
  always_comb
  begin
    x       = val_a;
    y       = op2;
    ci      = 1'b0;
    alu_res = 32'h0;
    case (op)
      conj_op, test_conjunction_op:         alu_res = val_a & op2;
      exclusive_or_op, test_equivalence_op: alu_res = val_a ^ op2;
      inclusive_or_op:                      alu_res = val_a | op2;
      copy_op:                              alu_res = op2;
      bit_clear_op:                         alu_res = val_a & ~op2;
      copy_inverted_op:                     alu_res = ~op2;
      minus_op, compare_op:
      begin
        y  = ~op2;
        ci = 1'b1;
      end
      reverse_minus_op:
      begin
        x  = op2;
        y  = ~val_a;
        ci = 1'b1;
      end
      sum_op, compare_negated_op: ci = 1'b0;
      sum_with_carry_op:          ci = status_r[`ST_C];
      minus_with_carry_op:
      begin
        y  = ~op2;
        ci = status_r[`ST_C];
      end
      reverse_minus_with_carry_op:
      begin
        x  = op2;
        y  = ~val_a;
        ci = status_r[`ST_C];
      end
      default: alu_res = 32'h0;
    endcase
    sum = {1'b0, x} + {1'b0, y} + {32'h0, ci};
    if (arith)
      alu_res = sum[31:0];
  end

  assign alu_c = sum[32];
  assign alu_v = (x[31] == y[31]) && (sum[31] != x[31]);

  // status and destination decisions
  always_comb
  begin
    stat_nxt = status_r;
    wr_dest  = 1'b0;
    wr_pc    = 1'b0;
    mode_chg = 1'b0;
    if (exec_r && !undef)
    begin
      if (rd_pc)
      begin
        // without flags only the pc bits change
        wr_pc = !is_test;
        if (s_bit)
        begin
          // flags from the top four bits
          // test forms update the status too
          stat_nxt[`ST_FLAGS] = alu_res[`ST_FLAGS];
          if (!user)
          begin
            // privileged load replaces irq and mode bits
            stat_nxt[`ST_IRQ]  = alu_res[`ST_IRQ];
            stat_nxt[`ST_MODE] = alu_res[`ST_MODE];
          end
          mode_chg = stat_nxt[`ST_MODE] != status_r[`ST_MODE];
        end
      end
      else
      begin
        wr_dest = !is_test;
        if (s_bit)
        begin
          stat_nxt[`ST_N] = alu_res[31];
          stat_nxt[`ST_Z] = alu_res == 32'h0;
          stat_nxt[`ST_C] = arith ? alu_c : sh_c;
          if (arith)
            stat_nxt[`ST_V] = alu_v;
        end
      end
    end
  end

  // status word; software writes lose to a same-cycle execution
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= `STAT_RST;
    else if (exec_r)
      status_r <= stat_nxt;
    else if (wr_acc && paddr == `OFS_STAT)
      status_r <= pwdata;
  end

  // instruction address doubles as the program counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      iaddr_r <= 32'h0;
    else if (wr_pc)
      iaddr_r <= (iaddr_r & ~`PC_MASK) | (alu_res & `PC_MASK);
    else if (wr_acc && paddr == `OFS_IADDR)
      iaddr_r <= pwdata;
  end

  // result and outcome of the last execution
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_r  <= 32'h0;
      info_r <= 8'h0;
    end
    else if (exec_r)
    begin
      // a refused form leaves the last result in place
      if (!undef)
        res_r <= alu_res;
      info_r[`INF_WR]      <= wr_dest;
      info_r[`INF_PCWR]    <= wr_pc;
      info_r[`INF_UNDEF]   <= undef;
      // flag lets software insert the no-op
      info_r[`INF_MODECHG] <= mode_chg;
      info_r[`INF_RD]      <= instr_r[`F_RD];
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_flag_exec;
    exec_r && !undef && s_bit && !rd_pc;
  endsequence
  sequence s_pc_exec;
    exec_r && !undef && rd_pc;
  endsequence
  sequence s_apb_wait;
    psel && penable && !pready_r;
  endsequence

  a_apb_answer: assert property (s_apb_wait |=> pready_r ##1 !pready_r)
    else $error("apb answer not one cycle");
  a_logic_v_hold: assert property (s_flag_exec ##0 !arith |=>
    status_r[`ST_V] == $past(status_r[`ST_V]) && status_r[`ST_C] == $past(sh_c))
    else $error("logical flag update wrong");
  a_arith_cv: assert property (s_flag_exec ##0 arith |=>
    status_r[`ST_C] == $past(alu_c) && status_r[`ST_V] == $past(alu_v))
    else $error("arithmetic carry or overflow wrong");
  a_zero_neg: assert property (s_flag_exec |=>
    status_r[`ST_Z] == (res_r == 32'h0) && status_r[`ST_N] == res_r[31])
    else $error("zero or negative flag wrong");
  a_no_s_hold: assert property (exec_r && !s_bit && !rd_pc |=> $stable(status_r))
    else $error("status moved without flag request");
  a_pc_only: assert property (s_pc_exec ##0 !s_bit |=> $stable(status_r)
    && info_r[`INF_PCWR] == !$past(is_test))
    else $error("pc write touched status");
  a_user_protect: assert property (s_pc_exec ##0 (s_bit && user) |=>
    $stable(status_r[`ST_IRQ]) && $stable(status_r[`ST_MODE])
    && status_r[`ST_FLAGS] == res_r[`ST_FLAGS])
    else $error("user mode protection broken");
  a_test_no_write: assert property (exec_r && is_test |=> !info_r[`INF_WR])
    else $error("test opcode wrote a result");
  a_undef_quiet: assert property (exec_r && undef |=>
    $stable(status_r) && $stable(res_r) && info_r[`INF_UNDEF] && !info_r[`INF_WR])
    else $error("bit seven form executed");
  a_rrx_carry: assert property (exec_r && !imm_sel && !reg_sh && sk == rotate_right
    && instr_r[`F_SAMT] == 5'h0 |-> op2 == {status_r[`ST_C], val_m[31:1]} && sh_c == val_m[0])
    else $error("extended rotate wrong");

endmodule // alu_dp
`default_nettype wire

// File: logic/alu_dp_pkg.sv
// types shared by the alu datapath
package alu_dp_pkg;
  typedef enum logic [3:0] {
    conj_op, exclusive_or_op, minus_op, reverse_minus_op,
    sum_op, sum_with_carry_op, minus_with_carry_op, reverse_minus_with_carry_op,
    test_conjunction_op, test_equivalence_op, compare_op, compare_negated_op,
    inclusive_or_op, copy_op, bit_clear_op, copy_inverted_op
  } alu_op_type;
  typedef enum logic [1:0] {
    logical_left_shift, logical_right_shift, arith_right_shift, rotate_right
  } shift_kind_type;
endpackage

// File: logic/alu_dp_regs.svh
// register offsets, instruction fields and reset values of the alu datapath
`ifndef ALU_DP_REGS_SVH
`define ALU_DP_REGS_SVH
// register byte offsets
`define OFS_INSTR    8'h00
`define OFS_OPA      8'h04
`define OFS_OPB      8'h08
`define OFS_CNT      8'h0c
`define OFS_IADDR    8'h10
`define OFS_STAT     8'h14
`define OFS_GO       8'h18
`define OFS_RES      8'h1c
`define OFS_INFO     8'h20
// instruction fields
`define F_IMM        25
`define F_OP         24:21
`define F_S          20
`define F_RN         19:16
`define F_RD         15:12
`define F_RS         11:8
`define F_SAMT       11:7
`define F_STYPE      6:5
`define F_B7         7
`define F_REGSH      4
`define F_RM         3:0
`define F_ROT        11:8
`define F_IMM8       7:0
// status word fields
`define ST_N         31
`define ST_Z         30
`define ST_C         29
`define ST_V         28
`define ST_FLAGS     31:28
`define ST_IRQ       27:26
`define ST_MODE      1:0
`define PC_MASK      32'h03fffffc
`define USER_MODE    2'h0
`define STAT_RST     32'h0c000003
// info register fields
`define INF_WR       0
`define INF_PCWR     1
`define INF_UNDEF    2
`define INF_MODECHG  3
`define INF_RD       7:4
// misc constants
`define PC_REG       4'hf
`define PC_AHEAD     32'h00000008
`define PC_AHEAD_REG 32'h0000000c
`define WORD_BITS    8'h20
`endif

// File: verif/test_alu_dp.sv
// self-checking bench for the alu datapath, driven through its apb registers
`timescale 1ns/1ps
`default_nettype none
`include "alu_dp_regs.svh"

module test_alu_dp;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_fail;
  int          checked;
  logic        last_err;
  logic [31:0] info;
  logic [31:0] v;

  alu_dp dut (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // 50 mhz clock
  always #10 pclk = ~pclk;

  task automatic conclude();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // bounded wait so a dead slave cannot hang the run
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk(32'h0, 32'h1);
    q        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask

  function automatic logic [31:0] x(input logic i, input logic [3:0] op, input logic s,
                                    input logic [3:0] rn, input logic [3:0] rd,
                                    input logic [11:0] lo);
    return {4'he, 2'b00, i, op, s, rn, rd, lo};
  endfunction

  // load operands, execute once, then compare result and status word
  task automatic t(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                   input logic [31:0] c, input logic [31:0] st, input logic [31:0] er,
                   input logic [31:0] es);
    logic [31:0] q;
    wr(`OFS_STAT, st);
    wr(`OFS_OPA, a);
    wr(`OFS_OPB, b);
    wr(`OFS_CNT, c);
    wr(`OFS_IADDR, 32'h0);
    wr(`OFS_INSTR, ins);
    wr(`OFS_GO, 32'h1);
    rd(`OFS_RES, q);
    chk(q, er);
    rd(`OFS_STAT, q);
    chk(q, es);
    rd(`OFS_INFO, info);
  endtask

  // watchdog, far beyond the roughly 1400 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude();
  end

  initial
  begin
    pclk = 1'b0; presetn = 1'b0; paddr = 8'h00; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; pwdata = 32'h0;
    n_fail = 0; checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_STAT, v);
    chk(v, 32'h0c000003);
    // unmapped address answers with an error and zero data
    rd(8'h24, v);
    chk({v[31:1], last_err}, 32'h1);
    // logical class: v kept, c from shifter, old c on lsl 0
    t(x(0,4'h0,1,4'h1,4'h2,12'h003), 32'hf0f000ff, 32'h0ff000f0, 0, 32'h3c000003,
      32'h00f000f0, 32'h3c000003);
    chk(info[0], 1'b1);
    t(x(0,4'h1,1,4'h1,4'h2,12'h283), 0, 32'h08000001, 0, 32'h0c000003,
      32'h00000020, 32'h2c000003);
    t(x(0,4'hc,1,4'h1,4'h2,12'h023), 0, 32'h80000000, 0, 32'h0c000003,
      32'h0, 32'h6c000003);
    t(x(0,4'hd,1,4'h1,4'h2,12'h043), 32'h12345678, 32'h80000000, 0, 32'h0c000003,
      32'hffffffff, 32'hac000003);
    t(x(0,4'hf,1,4'h1,4'h2,12'h063), 32'h5, 32'h3, 0, 32'h2c000003,
      32'h7ffffffe, 32'h2c000003);
    t(x(0,4'he,1,4'h1,4'h2,12'h263), 32'hffffffff, 32'hf, 0, 32'h0c000003,
      32'h0fffffff, 32'h2c000003);
    // arithmetic class
    t(x(0,4'h4,1,4'h1,4'h2,12'h003), 32'h7fffffff, 32'h1, 0, 32'h0c000003,
      32'h80000000, 32'h9c000003);
    t(x(0,4'h2,1,4'h1,4'h2,12'h003), 32'h5, 32'h5, 0, 32'h0c000003,
      32'h0, 32'h6c000003);
    t(x(0,4'h3,1,4'h1,4'h2,12'h003), 32'h1, 32'h0, 0, 32'h0c000003,
      32'hffffffff, 32'h8c000003);
    t(x(0,4'h5,1,4'h1,4'h2,12'h003), 32'hffffffff, 32'h0, 0, 32'h2c000003,
      32'h0, 32'h6c000003);
    t(x(0,4'h6,1,4'h1,4'h2,12'h003), 32'h5, 32'h3, 0, 32'h0c000003,
      32'h1, 32'h2c000003);
    t(x(0,4'h7,1,4'h1,4'h2,12'h003), 32'h3, 32'h5, 0, 32'h2c000003,
      32'h2, 32'h2c000003);
    // flag-only opcodes leave the destination alone
    t(x(0,4'h8,1,4'h1,4'h2,12'h003), 32'hf0, 32'h0f, 0, 32'h0c000003,
      32'h0, 32'h4c000003);
    chk(info[0], 1'b0);
    t(x(0,4'h9,1,4'h1,4'h2,12'h003), 32'h5, 32'h5, 0, 32'h0c000003,
      32'h0, 32'h4c000003);
    chk(info[0], 1'b0);
    t(x(0,4'ha,1,4'h1,4'h2,12'h003), 32'h3, 32'h5, 0, 32'h0c000003,
      32'hfffffffe, 32'h8c000003);
    t(x(0,4'hb,1,4'h1,4'h2,12'h003), 32'h80000000, 32'h80000000, 0, 32'h0c000003,
      32'h0, 32'h7c000003);
    chk(info[0], 1'b0);
    // register counts: 32, beyond 32, low byte only, zero byte
    t(x(0,4'hd,1,4'h1,4'h2,12'h413), 0, 32'h1, 32'h20, 32'h0c000003,
      32'h0, 32'h6c000003);
    t(x(0,4'hd,1,4'h1,4'h2,12'h433), 0, 32'hffffffff, 32'h21, 32'h2c000003,
      32'h0, 32'h4c000003);
    t(x(0,4'hd,1,4'h1,4'h2,12'h453), 0, 32'h80000000, 32'h40, 32'h0c000003,
      32'hffffffff, 32'hac000003);
    t(x(0,4'hd,1,4'h1,4'h2,12'h473), 0, 32'h80000001, 32'h20, 32'h0c000003,
      32'h80000001, 32'hac000003);
    t(x(0,4'hd,1,4'h1,4'h2,12'h473), 0, 32'hf, 32'hffffff24, 32'h0c000003,
      32'hf0000000, 32'hac000003);
    t(x(0,4'hd,1,4'h1,4'h2,12'h413), 0, 32'h12345678, 32'h100, 32'h2c000003,
      32'h12345678, 32'h2c000003);
    // rotated immediate operand
    t(x(1,4'hd,1,4'h1,4'h2,12'h4ab), 0, 0, 0, 32'h0c000003,
      32'hab000000, 32'hac000003);
    // no flag request keeps status; bit seven set refuses the instruction
    t(x(0,4'h4,0,4'h1,4'h2,12'h003), 32'h1, 32'h1, 0, 32'hfc000003,
      32'h2, 32'hfc000003);
    t(x(0,4'hd,1,4'h1,4'h2,12'h493), 0, 32'h1, 32'h4, 32'h0c000003,
      32'h2, 32'h0c000003);
    chk(info[2], 1'b1);
    // flag-load test from privileged mode clears every writable bit
    t(x(1,4'h9,1,4'hf,4'hf,12'h008), 0, 0, 0, 32'h0c000003,
      32'h0, 32'h0);
    chk(info[3], 1'b1);
    // user mode protects interrupt and mode bits
    t(x(1,4'hd,1,4'h1,4'hf,12'h4ff), 0, 0, 0, 32'h0,
      32'hff000000, 32'hf0000000);
    rd(`OFS_IADDR, v);
    chk(v, 32'h03000000);
    t(x(0,4'ha,1,4'h1,4'hf,12'h003), 32'hfc000008, 32'h5, 0, 32'h0,
      32'hfc000003, 32'hf0000000);
    rd(`OFS_IADDR, v);
    chk(v, 32'h0);
    t(x(0,4'hd,0,4'h1,4'hf,12'h003), 0, 32'h12345678, 0, 32'h0c000003,
      32'h12345678, 32'h0c000003);
    rd(`OFS_IADDR, v);
    chk(v, 32'h02345678);
    // pc as an operand: offsets and status bits by position
    t(x(0,4'hd,0,4'h1,4'h2,12'h41f), 0, 0, 0, 32'h0c000003,
      32'h0c00000f, 32'h0c000003);
    t(x(0,4'hd,0,4'h1,4'h2,12'h00f), 0, 0, 0, 32'h0c000003,
      32'h0c00000b, 32'h0c000003);
    t(x(0,4'hd,0,4'h1,4'h2,12'hf13), 0, 32'h1, 0, 32'h0c000003,
      32'h00000100, 32'h0c000003);
    t(x(0,4'h4,0,4'hf,4'h2,12'h413), 0, 0, 0, 32'h0c000003,
      32'h0000000c, 32'h0c000003);
    t(x(0,4'h4,0,4'hf,4'h2,12'h003), 0, 0, 0, 32'h0c000003,
      32'h00000008, 32'h0c000003);
    conclude();
  end
endmodule // test_alu_dp

`default_nettype wire
